// ### instr_core_pkg.sv
// Constants, encodings and carrier types shared by the instruction core.
package instr_core_pkg;

   // Word and field widths.
   localparam int WORD_W  = 24;             // Program word width.
   localparam int DATA_W  = 16;             // Working register width.
   localparam int OPC_W   = 8;              // Opcode field width.
   localparam int OPC_LSB = 16;             // Opcode sits in the top byte.
   localparam int REG_W   = 4;              // Register index width.
   localparam int NREG    = 16;             // Number of working registers.
   localparam int LIT5_W  = 5;              // Short literal width.
   localparam int LIT10_W = 10;             // Long literal width.
   localparam int FADDR_W = 13;             // File register address width.
   localparam int OFFS_W  = 16;             // Branch offset width.
   localparam int PC_MIN  = 17;             // Smallest usable program counter width.

   // Operand field positions inside a single word.
   localparam int BASE_LSB  = 12;           // First source register.
   localparam int DIND_BIT  = 11;           // Destination indirect modifier.
   localparam int DEST_LSB  = 7;            // Destination register.
   localparam int LITF_BIT  = 6;            // Second source is a literal.
   localparam int SIND_BIT  = 5;            // Second source indirect modifier.
   localparam int SRC_LSB   = 0;            // Second source register.
   localparam int LIT10_LSB = 4;            // Long literal position.
   localparam int FDIR_BIT  = 13;           // File form destination select.

   // Fixed register roles.
   localparam logic [REG_W-1:0] ACC_REG   = 4'h0; // Accumulator is working register zero.
   localparam logic [REG_W-1:0] FRAME_REG = 4'he; // Frame pointer.
   localparam logic [REG_W-1:0] STACK_REG = 4'hf; // Stack pointer.

   // Extra cycle counts.
   localparam logic [1:0] NOP_ONE = 2'h1;   // One trailing empty cycle.
   localparam logic [1:0] NOP_TWO = 2'h2;   // Two trailing empty cycles.

   // Opcodes; the first three are the only two-word instructions.
   localparam logic [OPC_W-1:0] OP_CALL  = 8'h02;
   localparam logic [OPC_W-1:0] OP_GOTO  = 8'h04;
   localparam logic [OPC_W-1:0] OP_MOVD  = 8'h0b;
   localparam logic [OPC_W-1:0] OP_NOP   = 8'h00;
   localparam logic [OPC_W-1:0] OP_JIND  = 8'h01;
   localparam logic [OPC_W-1:0] OP_IRET  = 8'h06;
   localparam logic [OPC_W-1:0] OP_BRAZ  = 8'h32;
   localparam logic [OPC_W-1:0] OP_JMP   = 8'h37;
   localparam logic [OPC_W-1:0] OP_XORW  = 8'h68;
   localparam logic [OPC_W-1:0] OP_SKIPZ = 8'ha6;
   localparam logic [OPC_W-1:0] OP_XORL  = 8'hb2;
   localparam logic [OPC_W-1:0] OP_XORF  = 8'hb6;
   localparam logic [OPC_W-1:0] OP_TRDL  = 8'hba;
   localparam logic [OPC_W-1:0] OP_TWTH  = 8'hbb;
   localparam logic [OPC_W-1:0] OP_TWTL  = 8'hbc;
   localparam logic [OPC_W-1:0] OP_UNLK  = 8'hfa;
   localparam logic [OPC_W-1:0] OP_ZX    = 8'hfb;

   // Sequencer states, one-hot.
   typedef enum logic [5:0] {
      ST_EXEC   = 6'h01,
      ST_NOP    = 6'h02,
      ST_SECOND = 6'h04,
      ST_TABLE  = 6'h08,
      ST_SKIP   = 6'h10,
      ST_DRAIN  = 6'h20
   } state_type;

   // Pending table operation.
   typedef enum logic [1:0] {
      TB_RDL = 2'h0,
      TB_WTH = 2'h1,
      TB_WTL = 2'h2
   } table_type;

   // Status flags.
   typedef struct packed {
      logic c;
      logic z;
      logic n;
   } flags_type;

   localparam flags_type FLAGS_RST = '{c: 1'b0, z: 1'b0, n: 1'b0};

   // Program memory write request.
   typedef struct packed {
      logic              we;
      logic              high;
      logic              low;
      logic [WORD_W-1:0] data;
   } progwr_type;

   // Operand fields pulled out of one program word.
   typedef struct packed {
      logic [OPC_W-1:0]   opc;
      logic [REG_W-1:0]   base;
      logic               dInd;
      logic [REG_W-1:0]   dest;
      logic               litF;
      logic               sInd;
      logic [REG_W-1:0]   src;
      logic [LIT5_W-1:0]  lit5;
      logic [LIT10_W-1:0] lit10;
      logic [FADDR_W-1:0] fAddr;
      logic               toFile;
      logic [OFFS_W-1:0]  offs;
      logic               isDouble;
   } decode_type;

   // True when the opcode starts a two-word instruction.
   function automatic logic isDouble(input logic [OPC_W-1:0] opc);
      isDouble = (opc == OP_CALL) || (opc == OP_GOTO) || (opc == OP_MOVD);
   endfunction : isDouble

endpackage : instr_core_pkg

// ### instr_fields.sv
// Operand field extraction for one program word.
`timescale 1ns/1ns
module instr_fields
   import instr_core_pkg::*;
(
   input  wire logic [WORD_W-1:0] word,   // Program word being decoded.
   output decode_type             dec     // Extracted fields.
);

   assign dec.opc      = word[OPC_LSB +: OPC_W];
   assign dec.base     = word[BASE_LSB +: REG_W];
   assign dec.dInd     = word[DIND_BIT];
   assign dec.dest     = word[DEST_LSB +: REG_W];
   assign dec.litF     = word[LITF_BIT];
   assign dec.sInd     = word[SIND_BIT];
   assign dec.src      = word[SRC_LSB +: REG_W];
   assign dec.lit5     = word[SRC_LSB +: LIT5_W];
   assign dec.lit10    = word[LIT10_LSB +: LIT10_W];
   assign dec.fAddr    = word[0 +: FADDR_W];
   assign dec.toFile   = word[FDIR_BIT];
   assign dec.offs     = word[0 +: OFFS_W];
   assign dec.isDouble = isDouble(word[OPC_LSB +: OPC_W]);

endmodule : instr_fields

// ### instr_core.sv
// Instruction decode, sequencing and execution of a slice of the core.
`timescale 1ns/1ns
module instr_core
   import instr_core_pkg::*;
#(
   parameter int PC_W = 23                     // Program counter width.
) (
   input  wire logic              clock,        // Instruction clock.
   input  wire logic              resetn,       // Asynchronous reset, active low.
   output logic [PC_W-1:0]        progAddr,     // Program memory word address.
   input  wire logic [WORD_W-1:0] progRdData,   // Word at progAddr.
   output progwr_type             progWrite,    // Program memory write request.
   output logic [DATA_W-1:0]      dataRdAddr,   // Data memory read address.
   input  wire logic [DATA_W-1:0] dataRdData,   // Data at dataRdAddr.
   output logic                   dataWe,       // Data memory write strobe.
   output logic [DATA_W-1:0]      dataWrAddr,   // Data memory write address.
   output logic [DATA_W-1:0]      dataWrData,   // Data memory write data.
   output flags_type              statusFlags,  // Current status flags.
   output logic                   nopCycle      // Current cycle executes as empty.
);

   // Refuse widths the jump target assembly cannot serve.
   if (PC_W < PC_MIN || PC_W > WORD_W) begin : g_bad_pc
      $error("PC_W out of range");
   end

   // Architectural and sequencing state.
   state_type            state_r, state_nxt;       // Sequencer state.
   logic [PC_W-1:0]      pc_r, pc_nxt;             // Address of the word in hand.
   logic [DATA_W-1:0]    accumulator_reg_r [NREG];            // Working registers.
   flags_type            flags_r, flags_nxt;       // Status flags.
   logic [PC_W-1:0]      retAddr_r, retAddr_nxt;   // Return address.
   logic [1:0]           nopLeft_r, nopLeft_nxt;   // Empty cycles still to run.
   logic [OFFS_W-1:0]    firstLow_r, firstLow_nxt; // Low 16 bits of a first word.
   logic [OPC_W-1:0]     firstOpc_r, firstOpc_nxt; // Opcode of a first word.
   logic [REG_W-1:0]     firstDst_r, firstDst_nxt; // Destination of a first word.
   table_type            tblOp_r, tblOp_nxt;       // Pending table operation.
   logic [PC_W-1:0]      tblRet_r, tblRet_nxt;     // Resume address after a table cycle.
   progwr_type           progWr_r, progWr_nxt;     // Registered program write.
   logic                 dWe_r, dWe_nxt;           // Registered data write strobe.
   logic [DATA_W-1:0]    dAddr_r, dAddr_nxt;       // Registered data write address.
   logic [DATA_W-1:0]    dVal_r, dVal_nxt;         // Registered data write value.
   logic                 wWe;                      // Working register write enable.
   logic [REG_W-1:0]     wIdx;                     // Working register write index.
   logic [DATA_W-1:0]    wVal;                     // Working register write value.
   logic                 wWe2;                     // Second register write, used by unlink.
   decode_type           dec;                      // Fields of the word in hand.

   // Field extraction of the word at the current address.
   instr_fields u_fields (
      .word (progRdData),
      .dec  (dec)
   );

   // Data reads see a write still posted in the output registers.
   wire                fwdHit  = dWe_r && (dAddr_r == dataRdAddr);
   wire [DATA_W-1:0]   rdVal   = fwdHit ? dVal_r : dataRdData;
   wire                isFile  = (dec.opc == OP_XORF);
   assign dataRdAddr = isFile ? DATA_W'(dec.fAddr) : accumulator_reg_r[dec.src];
   wire [DATA_W-1:0]   srcVal  = dec.sInd ? rdVal : accumulator_reg_r[dec.src];
   wire [DATA_W-1:0]   op2     = dec.litF ? DATA_W'(dec.lit5) : srcVal;
   wire [DATA_W-1:0]   baseVal = accumulator_reg_r[dec.base];
   wire [DATA_W-1:0]   xorReg  = baseVal ^ op2;
   wire [DATA_W-1:0]   xorLit  = accumulator_reg_r[dec.dest] ^ DATA_W'(dec.lit10);
   wire [DATA_W-1:0]   xorFile = rdVal ^ accumulator_reg_r[ACC_REG];
   wire [DATA_W-1:0]   zxVal   = {8'h00, srcVal[7:0]};
   wire [PC_W-1:0]     pcInc   = pc_r + PC_W'(1);
   wire [PC_W-1:0]     brTgt   = pcInc + PC_W'($signed(dec.offs));

   // Flag value after a result that touches only N and Z.
   function automatic flags_type setNZ(input flags_type f, input logic [DATA_W-1:0] v);
      flags_type r;
      r   = f;
      r.n = v[DATA_W-1];
      r.z = (v == '0);
      setNZ = r;
   endfunction : setNZ

   // Decode, sequencing and write-back for one instruction cycle.
   always_comb begin
      state_nxt    = ST_EXEC;
      pc_nxt       = pc_r;
      flags_nxt    = flags_r;
      retAddr_nxt  = retAddr_r;
      nopLeft_nxt  = nopLeft_r;
      firstLow_nxt = firstLow_r;
      firstOpc_nxt = firstOpc_r;
      firstDst_nxt = firstDst_r;
      tblOp_nxt    = tblOp_r;
      tblRet_nxt   = tblRet_r;
      progWr_nxt   = '0;
      dWe_nxt      = 1'b0;
      dAddr_nxt    = dAddr_r;
      dVal_nxt     = dVal_r;
      wWe          = 1'b0;
      wIdx         = dec.dest;
      wVal         = '0;
      wWe2         = 1'b0;
      case (state_r)
         ST_EXEC: begin
            pc_nxt = pcInc;
            case (dec.opc)
               OP_XORW, OP_ZX: begin
                  wVal      = (dec.opc == OP_ZX) ? zxVal : xorReg;
                  wWe       = !dec.dInd;
                  dWe_nxt   = dec.dInd;
                  dAddr_nxt = accumulator_reg_r[dec.dest];
                  dVal_nxt  = wVal;
                  if (dec.opc == OP_ZX) begin
                     flags_nxt = '{c: 1'b1, z: (zxVal == '0), n: 1'b0};
                  end else begin
                     flags_nxt = setNZ(flags_r, xorReg);
                  end
               end
               OP_XORL: begin
                  wVal      = xorLit;
                  wWe       = 1'b1;
                  flags_nxt = setNZ(flags_r, xorLit);
               end
               OP_XORF: begin
                  wIdx      = ACC_REG;
                  wVal      = xorFile;
                  wWe       = !dec.toFile;
                  dWe_nxt   = dec.toFile;
                  dAddr_nxt = DATA_W'(dec.fAddr);
                  dVal_nxt  = xorFile;
                  flags_nxt = setNZ(flags_r, xorFile);
               end
               OP_UNLK: begin
                  // Stack pointer takes the frame pointer; flags untouched.
                  wIdx = STACK_REG;
                  wVal = accumulator_reg_r[FRAME_REG];
                  wWe  = 1'b1;
                  wWe2 = 1'b1;
               end
               OP_JMP, OP_BRAZ: begin
                  // taken branch adds one empty cycle
                  if (dec.opc == OP_JMP || flags_r.z) begin
                     pc_nxt      = brTgt;
                     nopLeft_nxt = NOP_ONE;
                     state_nxt   = ST_NOP;
                  end
               end
               OP_JIND: begin
                  pc_nxt      = PC_W'(accumulator_reg_r[dec.src]);
                  nopLeft_nxt = NOP_ONE;
                  state_nxt   = ST_NOP;
               end
               OP_IRET: begin
                  pc_nxt      = retAddr_r;
                  nopLeft_nxt = NOP_TWO;
                  state_nxt   = ST_NOP;
               end
               OP_SKIPZ: begin
                  if (flags_r.z) begin
                     state_nxt = ST_SKIP;
                  end
               end
               OP_CALL, OP_GOTO, OP_MOVD: begin
                  firstLow_nxt = dec.offs;
                  firstOpc_nxt = dec.opc;
                  firstDst_nxt = dec.src;
                  state_nxt    = ST_SECOND;
               end
               OP_TRDL: begin
                  pc_nxt     = PC_W'(accumulator_reg_r[dec.src]);
                  tblOp_nxt  = TB_RDL;
                  tblRet_nxt = pcInc;
                  state_nxt  = ST_TABLE;
               end
               OP_TWTH, OP_TWTL: begin
                  pc_nxt          = PC_W'(accumulator_reg_r[dec.dest]);
                  tblOp_nxt       = (dec.opc == OP_TWTH) ? TB_WTH : TB_WTL;
                  tblRet_nxt      = pcInc;
                  progWr_nxt.we   = 1'b1;
                  progWr_nxt.high = (dec.opc == OP_TWTH);
                  progWr_nxt.low  = (dec.opc == OP_TWTL);
                  progWr_nxt.data = (dec.opc == OP_TWTH) ?
                                    {srcVal[7:0], 16'h0000} : {8'h00, srcVal};
                  state_nxt       = ST_TABLE;
               end
               default: begin
               end
            endcase
         end
         ST_SECOND: begin
            pc_nxt = pcInc;
            if (firstOpc_r == OP_MOVD) begin
               wIdx = firstDst_r;
               wVal = dec.offs;
               wWe  = 1'b1;
            end else begin
               pc_nxt = {progRdData[PC_W-PC_MIN:0], firstLow_r};
               if (firstOpc_r == OP_CALL) begin
                  retAddr_nxt = pcInc;
               end
            end
         end
         ST_TABLE: begin
            pc_nxt = tblRet_r;
            if (tblOp_r == TB_RDL) begin
               wIdx = firstDst_r;
               wVal = progRdData[DATA_W-1:0];
               wWe  = 1'b1;
            end
         end
         ST_SKIP: begin
            // two-word victim costs a cycle more
            if (dec.isDouble) begin
               pc_nxt    = pc_r + PC_W'(2);
               state_nxt = ST_DRAIN;
            end else begin
               pc_nxt = pcInc;
            end
         end
         ST_NOP: begin
            if (nopLeft_r != NOP_ONE) begin
               nopLeft_nxt = nopLeft_r - NOP_ONE;
               state_nxt   = ST_NOP;
            end
         end
         ST_DRAIN: begin
            state_nxt = ST_EXEC;
         end
         default: begin
            state_nxt = ST_EXEC;
         end
      endcase
   end

   // Table read destination is latched with the request.
   wire [REG_W-1:0] tblDst = (state_r == ST_EXEC && dec.opc == OP_TRDL) ? dec.dest : firstDst_r;

   // Sequencer and control registers.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r    <= ST_EXEC;
         pc_r       <= '0;
         flags_r    <= FLAGS_RST;
         retAddr_r  <= '0;
         nopLeft_r  <= '0;
         firstLow_r <= '0;
         firstOpc_r <= OP_NOP;
         firstDst_r <= '0;
         tblOp_r    <= TB_RDL;
         tblRet_r   <= '0;
      end else begin
         state_r    <= state_nxt;
         pc_r       <= pc_nxt;
         flags_r    <= flags_nxt;
         retAddr_r  <= retAddr_nxt;
         nopLeft_r  <= nopLeft_nxt;
         firstLow_r <= firstLow_nxt;
         firstOpc_r <= firstOpc_nxt;
         firstDst_r <= (state_r == ST_EXEC && dec.opc == OP_TRDL) ? tblDst : firstDst_nxt;
         tblOp_r    <= tblOp_nxt;
         tblRet_r   <= tblRet_nxt;
      end
   end

   // Posted memory writes.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         progWr_r <= '0;
         dWe_r    <= 1'b0;
         dAddr_r  <= '0;
         dVal_r   <= '0;
      end else begin
         progWr_r <= progWr_nxt;
         dWe_r    <= dWe_nxt;
         dAddr_r  <= dAddr_nxt;
         dVal_r   <= dVal_nxt;
      end
   end

   // Working register file; unlink also pops the frame pointer.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NREG; i++) begin
            accumulator_reg_r[i] <= '0;
         end
      end else begin
         if (wWe) begin
            accumulator_reg_r[wIdx] <= wVal;
         end
         if (wWe2) begin
            accumulator_reg_r[FRAME_REG] <= rdVal;
         end
      end
   end

   // Outputs.
   assign progAddr    = pc_r;
   assign progWrite   = progWr_r;
   assign dataWe      = dWe_r;
   assign dataWrAddr  = dAddr_r;
   assign dataWrData  = dVal_r;
   assign statusFlags = flags_r;
   assign nopCycle    = (state_r != ST_EXEC);

endmodule : instr_core

// ### instr_core_sva.sv
// Timing and flag checks on the ports of the instruction core.
`timescale 1ns/1ns
module instr_core_sva
   import instr_core_pkg::*;
#(
   parameter int PC_W = 23                   // Program counter width.
) (
   input wire logic              clock,       // Instruction clock.
   input wire logic              resetn,      // Reset, active low.
   input wire logic [PC_W-1:0]   progAddr,    // Program word address.
   input wire logic [WORD_W-1:0] progRdData,  // Word in hand.
   input progwr_type             progWrite,   // Program write request.
   input flags_type              statusFlags, // Status flags.
   input wire logic              nopCycle     // Empty cycle marker.
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // Decode of the word that executes in this cycle.
   wire [OPC_W-1:0] opc   = progRdData[WORD_W-1:OPC_LSB];
   wire             ex    = !nopCycle;
   wire             isXor = opc == OP_XORW || opc == OP_XORL || opc == OP_XORF;
   wire             isTab = opc == OP_TRDL || opc == OP_TWTH || opc == OP_TWTL;
   wire             twReq = ex && (opc == OP_TWTH || opc == OP_TWTL);
   wire [PC_W-1:0]  jmpTgt = progAddr + PC_W'(1) + PC_W'(signed'(progRdData[15:0]));
   property p_nop; ex && opc == OP_NOP |=> ex && progAddr == $past(progAddr) + 1'b1 && $stable(statusFlags); endproperty
   a_nop: assert property (p_nop) else $error("empty word misbehaved");
   property p_jmp; ex && (opc == OP_JMP || opc == OP_BRAZ && statusFlags.z) |=> !ex && progAddr == $past(jmpTgt) ##1 ex; endproperty
   a_jmp: assert property (p_jmp) else $error("branch timing wrong");
   property p_brn; ex && opc == OP_BRAZ && !statusFlags.z |=> ex && progAddr == $past(progAddr) + 1'b1; endproperty
   a_brn: assert property (p_brn) else $error("untaken branch slow");
   property p_dbl; ex && (opc == OP_CALL || opc == OP_GOTO || opc == OP_MOVD) |=> !ex ##1 ex; endproperty
   a_dbl: assert property (p_dbl) else $error("double word timing wrong");
   property p_one; ex && (isXor || opc == OP_ZX || opc == OP_UNLK) |=> ex; endproperty
   a_one: assert property (p_one) else $error("single cycle op stretched");
   property p_xorc; ex && isXor |=> statusFlags.c == $past(statusFlags.c); endproperty
   a_xorc: assert property (p_xorc) else $error("carry changed by xor");
   property p_zx; ex && opc == OP_ZX |=> statusFlags.c && !statusFlags.n; endproperty
   a_zx: assert property (p_zx) else $error("zero extend flags wrong");
   property p_tab; ex && isTab |=> !ex && $stable(statusFlags) ##1 ex && $stable(statusFlags); endproperty
   a_tab: assert property (p_tab) else $error("table op timing or flags wrong");
   property p_twh; ex && opc == OP_TWTH |=> progWrite.we && progWrite.high && !progWrite.low && progWrite.data[15:0] == 16'h0; endproperty
   a_twh: assert property (p_twh) else $error("high table write wrong");
   property p_twl; ex && opc == OP_TWTL |=> progWrite.we && progWrite.low && !progWrite.high && progWrite.data[23:16] == 8'h0; endproperty
   a_twl: assert property (p_twl) else $error("low table write wrong");
   property p_wsrc; progWrite.we |-> $past(twReq); endproperty
   a_wsrc: assert property (p_wsrc) else $error("stray program write");
   c_jmp: cover property (ex && opc == OP_JMP);
   c_tab: cover property (ex && isTab);
   c_skp: cover property (ex && opc == OP_SKIPZ && statusFlags.z);
endmodule : instr_core_sva

// ### core_memories.sv
// Program and data memory answering the core without delay.
`timescale 1ns/1ns
module core_memories
   import instr_core_pkg::*;
(
   input wire logic              clock,      // Instruction clock.
   input wire logic [7:0]        progAddr,   // Program word address.
   output logic [WORD_W-1:0]     progRdData, // Word at progAddr.
   input progwr_type             progWrite,  // Program write request.
   input wire logic [7:0]        rdAddr,     // Data read address.
   output logic [DATA_W-1:0]     rdData,     // Data at rdAddr.
   input wire logic              we,         // Data write strobe.
   input wire logic [7:0]        wrAddr,     // Data write address.
   input wire logic [DATA_W-1:0] wrData      // Data write value.
);
   logic [WORD_W-1:0] prog [256];            // Program words.
   logic [DATA_W-1:0] data [256];            // Data words.
   assign progRdData = prog[progAddr];
   assign rdData = data[rdAddr];
   // Writes land on the edge that samples the request.
   always @(posedge clock) begin
      if (progWrite.we && progWrite.high) prog[progAddr][23:16] <= progWrite.data[23:16];
      if (progWrite.we && progWrite.low) prog[progAddr][15:0] <= progWrite.data[15:0];
      if (we) data[wrAddr] <= wrData;
   end
endmodule : core_memories

// ### tb.sv
// Self-checking bench for the instruction core.
`timescale 1ns/1ns
module tb;
   import instr_core_pkg::*;
   logic              clock = 1'b0;          // Instruction clock.
   logic              resetn = 1'b0;         // Reset, active low.
   logic [22:0]       progAddr;
   logic [WORD_W-1:0] progRdData;
   progwr_type        progWrite;
   logic [DATA_W-1:0] dataRdAddr, dataRdData, dataWrAddr, dataWrData;
   logic              dataWe, nopCycle;
   flags_type         statusFlags;
   int                mismatches = 0;
   int                tests_run = 0;
   int                cyc;                   // Cycles since reset release.
   logic [31:0]       expWr [$];             // Expected data writes.
   logic [15:0]       a, b, c, v, ta;
   logic [9:0]        k;
   logic [4:0]        l;
   // Opening words, landing address and cycle count of each timing case.
   logic [23:0] tw [10][3] = '{
      '{{OP_JMP, 16'h0004}, 24'h0, 24'h0}, '{{OP_BRAZ, 16'h0004}, 24'h0, 24'h0},
      '{{OP_ZX, 16'h0305}, {OP_BRAZ, 16'h0003}, 24'h0}, '{{OP_ZX, 16'h0305}, {OP_SKIPZ, 16'h0}, 24'h0},
      '{{OP_ZX, 16'h0305}, {OP_SKIPZ, 16'h0}, {OP_GOTO, 16'h0009}}, '{{OP_GOTO, 16'h0009}, 24'h0, 24'h0},
      '{{OP_CALL, 16'h0006}, 24'h0, 24'h0}, '{{OP_MOVD, 16'h0002}, 24'h000009, {OP_JIND, 16'h0002}},
      '{{OP_SKIPZ, 16'h0}, 24'h0, 24'h0}, '{{OP_NOP, 16'ha5c3}, 24'h0, 24'h0}};
   int tAddr [10] = '{5, 1, 5, 3, 4, 9, 2, 9, 1, 1};
   int tCyc [10] = '{2, 1, 3, 3, 4, 2, 5, 4, 1, 1};

   always #25 clock = ~clock;

   instr_core #(.PC_W(23)) uut (
      .clock(clock), .resetn(resetn), .progAddr(progAddr), .progRdData(progRdData),
      .progWrite(progWrite), .dataRdAddr(dataRdAddr), .dataRdData(dataRdData), .dataWe(dataWe),
      .dataWrAddr(dataWrAddr), .dataWrData(dataWrData), .statusFlags(statusFlags), .nopCycle(nopCycle));
   core_memories mem (
      .clock(clock), .progAddr(progAddr[7:0]), .progRdData(progRdData), .progWrite(progWrite),
      .rdAddr(dataRdAddr[7:0]), .rdData(dataRdData), .we(dataWe), .wrAddr(dataWrAddr[7:0]), .wrData(dataWrData));

   // Compares one value and counts it.
   task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
      tests_run++;
      if (got !== want) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask : check

   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run

   // Resets the core over junk empty program words and cleared data words.
   task automatic restart();
      @(negedge clock);
      check(32'(expWr.size()), 32'h0, "writes left");
      resetn = 1'b0;
      expWr.delete();
      for (int i = 0; i < 256; i++) begin
         mem.prog[i] = {OP_NOP, 16'($urandom)};
         mem.data[i] = 16'h0;
      end
      repeat (20) @(negedge clock);
      resetn = 1'b1;
      cyc = 0;
   endtask : restart

   // Runs until addr executes, then compares the cycle total.
   task automatic runTo(input int addr, input int want);
      int n;
      n = 0;
      do begin
         @(negedge clock);
         cyc++;
         n++;
      end while (n < 60 && !(progAddr === 23'(addr) && nopCycle === 1'b0));
      check(32'(cyc), 32'(want), "cycles");
      if (n >= 60) complete_run();
   endtask : runTo

   // Runs to addr and compares flags against result r and carry cf.
   task automatic step(input int addr, input int want, input logic [15:0] r, input logic cf);
      runTo(addr, want);
      check({29'h0, statusFlags}, {29'h0, cf, r == 16'h0, r[15]}, "flags");
   endtask : step

   // Register-operand word.
   function automatic logic [23:0] rw(logic [7:0] op, logic [3:0] bs, logic di, logic [3:0] d, logic lf, logic [4:0] s);
      return {op, bs, di, d, lf, 1'b0, s};
   endfunction : rw

   // Each data write must be the next one the model expects.
   always @(posedge clock) begin
      if (resetn && dataWe === 1'b1) begin
         if (expWr.size() == 0) check(32'h1, 32'h0, "spare write");
         else check({dataWrAddr, dataWrData}, expWr.pop_front(), "write");
      end
   end

   initial begin
      void'($urandom(2212));
      // Exclusive-OR forms and zero extension.
      restart();
      a = 16'($urandom);
      b = 16'($urandom);
      c = 16'($urandom);
      k = {3'($urandom), 4'h1, 3'($urandom)};
      l = 5'($urandom);
      mem.data[8'h40] = c;
      mem.prog[0] = {OP_MOVD, 16'h0000};
      mem.prog[1] = {8'h00, a};
      mem.prog[2] = {OP_MOVD, 16'h0001};
      mem.prog[3] = {8'h00, b};
      mem.prog[4] = rw(OP_ZX, 4'h0, 1'b0, 4'h6, 1'b0, 5'h00);
      mem.prog[5] = rw(OP_XORW, 4'h1, 1'b1, 4'h3, 1'b0, 5'h00);
      mem.prog[6] = {OP_XORF, 3'b001, 13'h0040};
      mem.prog[7] = {OP_XORF, 3'b000, 13'h0040};
      mem.prog[8] = {OP_XORL, 2'b00, k, 4'h0};
      mem.prog[9] = rw(OP_XORW, 4'h1, 1'b1, 4'h4, 1'b1, l);
      expWr = '{{16'h0, a ^ b}, {16'h40, c ^ a}, {16'h0, b ^ {6'h0, k} ^ {11'h0, l}}};
      step(5, 5, {8'h0, a[7:0]}, 1'b1);
      step(6, 6, a ^ b, 1'b1);
      step(7, 7, c ^ a, 1'b1);
      step(8, 8, c, 1'b1);
      step(9, 9, b ^ {6'h0, k}, 1'b1);
      step(10, 10, b ^ {6'h0, k} ^ {11'h0, l}, 1'b1);
      // Table writes then a table read of the same word.
      restart();
      v = 16'($urandom);
      ta = {9'h1, 7'($urandom)};
      mem.prog[0] = {OP_MOVD, 16'h0001};
      mem.prog[1] = {8'h00, ta};
      mem.prog[2] = {OP_MOVD, 16'h0002};
      mem.prog[3] = {8'h00, v};
      mem.prog[4] = rw(OP_TWTL, 4'h0, 1'b0, 4'h1, 1'b0, 5'h02);
      mem.prog[5] = rw(OP_TWTH, 4'h0, 1'b0, 4'h1, 1'b0, 5'h02);
      mem.prog[6] = rw(OP_TRDL, 4'h0, 1'b0, 4'h0, 1'b0, 5'h01);
      mem.prog[7] = {OP_XORF, 3'b001, 13'h0040};
      expWr.push_back({16'h40, v});
      step(7, 10, 16'h1, 1'b0);
      step(8, 11, v, 1'b0);
      check({8'h0, mem.prog[ta[7:0]]}, {8'h0, v[7:0], v}, "table word");
      // Branches, skips, calls and double words.
      for (int t = 0; t < 10; t++) begin
         restart();
         for (int i = 0; i < 4; i++) mem.prog[i] = (i < 3) ? tw[t][i] : 24'h0;
         mem.prog[6] = {OP_IRET, 16'h0000};
         runTo(tAddr[t], tCyc[t]);
      end
      complete_run();
   end
endmodule : tb

bind instr_core instr_core_sva #(.PC_W(PC_W)) chk (
   .clock(clock), .resetn(resetn), .progAddr(progAddr), .progRdData(progRdData),
   .progWrite(progWrite), .statusFlags(statusFlags), .nopCycle(nopCycle));
